// ### hdl/lre_pkg.sv
// Constants, register map and types for the left-rotate-with-extension slice
package lre_pkg;

    localparam int LRE_DATA_W = 32;
    localparam int LRE_ADDR_W = 8;
    localparam int LRE_AMT_W = 5;

    // Register byte offsets
    localparam logic [7:0] LRE_OFF_SOURCE = 8'h00;
    localparam logic [7:0] LRE_OFF_COUNT = 8'h04;
    localparam logic [7:0] LRE_OFF_CMD = 8'h08;
    localparam logic [7:0] LRE_OFF_EXT = 8'h0C;
    localparam logic [7:0] LRE_OFF_DEST = 8'h10;
    localparam logic [7:0] LRE_OFF_CR0 = 8'h14;
    localparam logic [7:0] LRE_OFF_XER = 8'h18;
    localparam logic [7:0] LRE_OFF_STATUS = 8'h1C;

    // Command register fields
    localparam int LRE_CMD_OP_LSB = 0;
    localparam int LRE_CMD_REC_BIT = 2;
    localparam int LRE_CMD_IMM_LSB = 8;
    // Rotate amount in the count operand: big-endian bits 27..31
    localparam int LRE_CNT_AMT_LSB = 0;

    // Exception register fields
    localparam int LRE_XER_SO_BIT = 31;
    localparam int LRE_XER_OV_BIT = 30;
    localparam int LRE_XER_CA_BIT = 29;

    // Condition field 0 layout
    localparam int LRE_CR0_NEG_BIT = 3;
    localparam int LRE_CR0_POS_BIT = 2;
    localparam int LRE_CR0_ZERO_BIT = 1;
    localparam int LRE_CR0_SO_BIT = 0;

    // Status register fields
    localparam int LRE_STS_OP_LSB = 0;
    localparam int LRE_STS_BUSY_BIT = 2;
    localparam int LRE_STS_BADOP_BIT = 3;

    localparam logic [31:0] LRE_RESET_WORD = 32'h0000_0000;
    localparam logic [3:0] LRE_RESET_CR0 = 4'h0;
    localparam logic [31:0] LRE_ALL_ONES = 32'hFFFF_FFFF;

    localparam logic [1:0] LRE_RESP_OKAY = 2'h0;
    localparam logic [1:0] LRE_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LRE_OP_REG_MERGE = 2'b00,
        LRE_OP_IMM_MASK = 2'b01,
        LRE_OP_IMM_MERGE = 2'b10,
        LRE_OP_NONE = 2'b11
    } lre_op_t;

    typedef enum logic {
        LRE_ST_IDLE = 1'b0,
        LRE_ST_EXEC = 1'b1
    } lre_state_t;

endpackage

// ### hdl/lre_rotate_mask.sv
// Rotator, mask generator and masked merge of the rotate slice
`timescale 1ns/1ns
module lre_rotate_mask
    import lre_pkg::*;
(
    input wire logic [31:0] sourceWord,
    input wire logic [4:0] amount,
    input wire logic [31:0] extOld,
    input wire logic mergeSel,
    output logic [31:0] rotated,
    output logic [31:0] mask,
    output logic [31:0] result
);
    logic [63:0] doubled;

    assign doubled = {sourceWord, sourceWord} << amount;
    assign rotated = doubled[63:32];
    assign mask = LRE_ALL_ONES << amount;

    // Ones take the rotated bit, zeros take old extension or zero
    genvar i;
    generate
        for (i = 0; i < LRE_DATA_W; i++) begin : g_bit
            assign result[i] = mask[i] ? rotated[i]
                             : (mergeSel & extOld[i]);
        end
    endgenerate
endmodule // lre_rotate_mask

// ### hdl/lre_rotate_unit.sv
// Left-rotate with extension register slice behind an AXI4-Lite port
// What this block does
// - Register-count merge rotates left by count operand bits 27..31.
// - Register-count merge: extension gets rotated, destination merged.
// - Mask is 32 minus N ones on top, N zeros below.
// - No form of these rotates alters the exception register.
// - Record flag set updates condition field 0; clear leaves it.
// - Immediate masking form takes N from the immediate count field.
// - Immediate mask: extension rotated; destination rotated AND mask.
// - Immediate merge: destination merged, extension gets rotated word.
// - Merge uses the old extension value before it is overwritten.
`timescale 1ns/1ns
module lre_rotate_unit
    import lre_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] destResult,
    output logic [31:0] extensionRegister,
    output logic [3:0] cr0Field,
    output logic execDone
);
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a[1:0] == 2'b00) && (a <= LRE_OFF_STATUS);
    endfunction

    function automatic logic addr_writable(input logic [7:0] a);
        addr_writable = (a == LRE_OFF_SOURCE) || (a == LRE_OFF_COUNT) ||
                        (a == LRE_OFF_CMD) || (a == LRE_OFF_EXT) ||
                        (a == LRE_OFF_XER);
    endfunction

    function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        apply_strobe = res;
    endfunction

    // Register file
    logic [31:0] sourceOperand_r, countOperand_r, cmd_r, extReg_r;
    logic [31:0] dest_r, xer_r;
    logic [3:0] cr0_r;
    logic badOp_r, done_r;
    lre_state_t state_r, state_nxt;

    // Bus side state
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic awHeld_r, wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic awHeld_nxt, wHeld_nxt, bvalid_nxt, rvalid_nxt;
    logic awHit, wHit, arHit, doWrite;

    // Decoded command
    lre_op_t cmdOp;
    logic cmdRecord, mergeSel;
    logic [4:0] cmdImm, amount;
    logic [31:0] rotated, mask, merged, newCmd;

    assign cmdOp = lre_op_t'(cmd_r[LRE_CMD_OP_LSB +: 2]);
    assign cmdRecord = cmd_r[LRE_CMD_REC_BIT];
    assign cmdImm = cmd_r[LRE_CMD_IMM_LSB +: LRE_AMT_W];
    assign newCmd = apply_strobe(cmd_r, wData_r, wStrb_r);

    always_comb begin
        amount = cmdImm;
        mergeSel = 1'b0;
        case (cmdOp)
            LRE_OP_REG_MERGE: begin
                amount = countOperand_r[LRE_CNT_AMT_LSB +: LRE_AMT_W];
                mergeSel = 1'b1;
            end
            LRE_OP_IMM_MASK: mergeSel = 1'b0;
            LRE_OP_IMM_MERGE: mergeSel = 1'b1;
            default: mergeSel = 1'b0;
        endcase
    end

    lre_rotate_mask u_rot (
        .sourceWord(sourceOperand_r),
        .amount(amount),
        .extOld(extReg_r),
        .mergeSel(mergeSel),
        .rotated(rotated),
        .mask(mask),
        .result(merged)
    );

    // Handshake bookkeeping
    assign awHit = awvalid && awready_r;
    assign wHit = wvalid && wready_r;
    assign arHit = arvalid && arready_r;
    assign doWrite = awHeld_r && wHeld_r && !bvalid_r &&
                     (state_r == LRE_ST_IDLE);

    always_comb begin
        awHeld_nxt = awHeld_r ? !doWrite : awHit;
        wHeld_nxt = wHeld_r ? !doWrite : wHit;
        bvalid_nxt = doWrite || (bvalid_r && !bready);
        rvalid_nxt = arHit || (rvalid_r && !rready);
        case (state_r)
            LRE_ST_IDLE: begin
                if (doWrite && awAddr_r == LRE_OFF_CMD &&
                    newCmd[LRE_CMD_OP_LSB +: 2] != LRE_OP_NONE) begin
                    state_nxt = LRE_ST_EXEC;
                end else begin
                    state_nxt = LRE_ST_IDLE;
                end
            end
            LRE_ST_EXEC: state_nxt = LRE_ST_IDLE;
            default: state_nxt = LRE_ST_IDLE;
        endcase
    end

    // Write channel
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= LRE_RESET_WORD;
            wStrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= LRE_RESP_OKAY;
        end else begin
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            if (awHit) begin
                awAddr_r <= awaddr;
            end
            if (wHit) begin
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            awready_r <= !awHeld_nxt && !bvalid_nxt &&
                         (state_nxt == LRE_ST_IDLE);
            wready_r <= !wHeld_nxt && !bvalid_nxt &&
                        (state_nxt == LRE_ST_IDLE);
            bvalid_r <= bvalid_nxt;
            if (doWrite) begin
                bresp_r <= addr_writable(awAddr_r) ? LRE_RESP_OKAY
                                                   : LRE_RESP_SLVERR;
            end
        end
    end

    // Read channel
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= LRE_RESET_WORD;
            rresp_r <= LRE_RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (arHit) begin
                rresp_r <= addr_mapped(araddr) ? LRE_RESP_OKAY
                                               : LRE_RESP_SLVERR;
                case (araddr)
                    LRE_OFF_SOURCE: rdata_r <= sourceOperand_r;
                    LRE_OFF_COUNT: rdata_r <= countOperand_r;
                    LRE_OFF_CMD: rdata_r <= cmd_r;
                    LRE_OFF_EXT: rdata_r <= extReg_r;
                    LRE_OFF_DEST: rdata_r <= dest_r;
                    LRE_OFF_CR0: rdata_r <= {28'h0, cr0_r};
                    LRE_OFF_XER: rdata_r <= xer_r;
                    LRE_OFF_STATUS: begin
                        rdata_r <= {28'h0, badOp_r,
                                    (state_r == LRE_ST_EXEC), cmd_r[1:0]};
                    end
                    default: rdata_r <= LRE_RESET_WORD;
                endcase
            end
        end
    end

    // Operand and command registers written by software
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sourceOperand_r <= LRE_RESET_WORD;
            countOperand_r <= LRE_RESET_WORD;
            cmd_r <= LRE_RESET_WORD;
            xer_r <= LRE_RESET_WORD;
            badOp_r <= 1'b0;
        end else if (doWrite) begin
            case (awAddr_r)
                LRE_OFF_SOURCE: begin
                    sourceOperand_r <= apply_strobe(sourceOperand_r,
                                                    wData_r, wStrb_r);
                end
                LRE_OFF_COUNT: begin
                    countOperand_r <= apply_strobe(countOperand_r,
                                                   wData_r, wStrb_r);
                end
                LRE_OFF_CMD: begin
                    cmd_r <= newCmd;
                    badOp_r <= newCmd[LRE_CMD_OP_LSB +: 2] == LRE_OP_NONE;
                end
                // Only software touches this; rotates never do
                LRE_OFF_XER: xer_r <= apply_strobe(xer_r, wData_r,
                                                   wStrb_r);
                default: begin
                end
            endcase
        end
    end

    // Execution: extension, destination and condition field
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            extReg_r <= LRE_RESET_WORD;
            dest_r <= LRE_RESET_WORD;
            cr0_r <= LRE_RESET_CR0;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == LRE_ST_EXEC);
            if (state_r == LRE_ST_EXEC) begin
                // Merge read old extension in this same edge
                extReg_r <= rotated;
                dest_r <= merged;
                if (cmdRecord) begin
                    cr0_r[LRE_CR0_NEG_BIT] <= $signed(merged) < 0;
                    cr0_r[LRE_CR0_POS_BIT] <= $signed(merged) > 0;
                    cr0_r[LRE_CR0_ZERO_BIT] <= merged == LRE_RESET_WORD;
                    cr0_r[LRE_CR0_SO_BIT] <= xer_r[LRE_XER_SO_BIT];
                end
            end else if (doWrite && awAddr_r == LRE_OFF_EXT) begin
                extReg_r <= apply_strobe(extReg_r, wData_r, wStrb_r);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= LRE_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign destResult = dest_r;
    assign extensionRegister = extReg_r;
    assign cr0Field = cr0_r;
    assign execDone = done_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic exec;
    logic [31:0] expRot;
    assign exec = (state_r == LRE_ST_EXEC);
    assign expRot = (sourceOperand_r << amount) |
                    (sourceOperand_r >> (6'd32 - {1'b0, amount}));

    a_count_from_reg: assert property (
        exec && cmdOp == LRE_OP_REG_MERGE |-> amount == countOperand_r[4:0])
        else $error("rotate count not taken from count operand");
    a_count_from_imm: assert property (
        exec && cmdOp != LRE_OP_REG_MERGE |-> amount == cmdImm)
        else $error("rotate count not taken from immediate field");
    a_mask_shape: assert property (
        exec |-> mask == ~((32'h1 << amount) - 32'h1))
        else $error("mask shape wrong");
    a_ext_gets_rot: assert property (
        exec |=> extReg_r == $past(expRot))
        else $error("extension register not loaded with rotated word");
    a_immmask_dest: assert property (
        exec && cmdOp == LRE_OP_IMM_MASK |=>
        dest_r == ($past(expRot) & $past(mask)))
        else $error("masked destination wrong");
    a_merge_old_ext: assert property (
        exec && mergeSel |=>
        ((dest_r ^ $past(extReg_r)) & ~$past(mask)) == 32'h0)
        else $error("merge did not keep old extension bits");
    a_merge_rot_bits: assert property (
        exec && mergeSel |=> ((dest_r ^ extReg_r) & $past(mask)) == 32'h0)
        else $error("merge did not take rotated bits");
    a_xer_untouched: assert property (
        exec |=> xer_r == $past(xer_r))
        else $error("exception register changed by rotate");
    a_cr0_hold: assert property (
        exec && !cmdRecord |=> $stable(cr0_r))
        else $error("condition field changed without record");
    a_cr0_flags: assert property (
        exec && cmdRecord |=> cr0_r == {dest_r[31], !dest_r[31] &&
        dest_r != 32'h0, dest_r == 32'h0, $past(xer_r[LRE_XER_SO_BIT])})
        else $error("condition field flags wrong");
    a_cmd_to_done: assert property (
        doWrite && awAddr_r == LRE_OFF_CMD && state_nxt == LRE_ST_EXEC
        |-> ##2 done_r)
        else $error("command did not complete in two cycles");

    c_reg_merge: cover property (exec && cmdOp == LRE_OP_REG_MERGE);
    c_imm_mask: cover property (exec && cmdOp == LRE_OP_IMM_MASK);
    c_imm_merge: cover property (exec && cmdOp == LRE_OP_IMM_MERGE);
    c_record: cover property (exec && cmdRecord ##1 cr0_r != 4'h0);
endmodule // lre_rotate_unit

// ### tb/lre_decoder_model.sv
// Far-side model: decoder and register file issuing slice accesses
`timescale 1ns/1ns
module lre_decoder_model
    import lre_pkg::*;
(
    input wire logic clock,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    localparam int WAIT_MAX = 1000;

    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // Released payloads are inverted so stale values cannot look valid
    task automatic busWrite(input logic [7:0] addr, input logic [31:0] data,
                            input logic [3:0] strb,
                            output logic [1:0] resp, output bit ok);
        int n;
        ok = 1'b0;
        resp = 2'h3;
        @(posedge clock);
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= data;
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < WAIT_MAX && !ok; n++) begin
            @(posedge clock);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~addr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~data;
            end
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask

    task automatic busRead(input logic [7:0] addr, output logic [31:0] data,
                           output logic [1:0] resp, output bit ok);
        int n;
        ok = 1'b0;
        resp = 2'h3;
        data = 32'h0000_0000;
        @(posedge clock);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < WAIT_MAX && !ok; n++) begin
            @(posedge clock);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~addr;
            end
            if (rvalid && rready) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask

    // Decoder routes the immediate count into the command word
    task automatic issueOp(input lre_op_t op, input logic [4:0] imm,
                           input logic rec, output logic [1:0] resp,
                           output bit ok);
        logic [31:0] cmd;
        cmd = 32'h0000_0000;
        cmd[LRE_CMD_IMM_LSB +: 5] = imm;
        cmd[LRE_CMD_REC_BIT] = rec;
        cmd[LRE_CMD_OP_LSB +: 2] = op;
        busWrite(LRE_OFF_CMD, cmd, 4'hF, resp, ok);
    endtask
endmodule // lre_decoder_model

// ### tb/lre_rotate_unit_tb.sv
// Self-checking bench for the left-rotate slice
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    nTests++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module lre_rotate_unit_tb
    import lre_pkg::*;
;
    typedef struct packed {
        lre_op_t op;
        logic [31:0] src;
        logic [31:0] cnt;
        logic [4:0] imm;
        logic rec;
        logic [31:0] ext;
        logic [31:0] xer;
    } lre_case_t;

    logic clock, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, execDone;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, destResult, extensionRegister, rdVal;
    logic [3:0] wstrb, cr0Field, expCr0;
    logic [1:0] bresp, rresp;
    int mismatches, nTests;
    lre_case_t cases [8];

    lre_rotate_unit lre_rotate_unit_inst (.clock(clock), .rst_b(rst_b),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .destResult(destResult),
        .extensionRegister(extensionRegister), .cr0Field(cr0Field),
        .execDone(execDone));

    lre_decoder_model lre_decoder_model_inst (.clock(clock),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    always #4 clock = ~clock;

    task automatic test_done();
        if (mismatches == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] rotl(input logic [31:0] w,
                                         input logic [4:0] n);
        return (w << n) | (w >> (32 - int'(n)));
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        bit ok;
        lre_decoder_model_inst.busWrite(a, d, s, r, ok);
        if (!ok) begin
            mismatches++;
            test_done();
        end
        `CHK(r, er)
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        logic [1:0] r;
        bit ok;
        lre_decoder_model_inst.busRead(a, d, r, ok);
        if (!ok) begin
            mismatches++;
            test_done();
        end
        `CHK(r, er)
    endtask

    task automatic runCase(input lre_case_t c);
        logic [4:0] n;
        logic [31:0] rot, msk, expDest, d;
        logic [1:0] r;
        bit ok;
        int k;
        n = (c.op == LRE_OP_REG_MERGE) ? c.cnt[4:0] : c.imm;
        rot = rotl(c.src, n);
        msk = LRE_ALL_ONES << n;
        expDest = (rot & msk) |
                  ((c.op == LRE_OP_IMM_MASK) ? 32'h0 : c.ext & ~msk);
        if (c.rec) begin
            expCr0 = {expDest[31], !expDest[31] && expDest != 32'h0,
                      expDest == 32'h0, c.xer[31]};
        end
        wr(LRE_OFF_EXT, c.ext, 4'hF, LRE_RESP_OKAY);
        wr(LRE_OFF_SOURCE, c.src, 4'hF, LRE_RESP_OKAY);
        wr(LRE_OFF_COUNT, c.cnt, 4'hF, LRE_RESP_OKAY);
        wr(LRE_OFF_XER, c.xer, 4'hF, LRE_RESP_OKAY);
        lre_decoder_model_inst.issueOp(c.op, c.imm, c.rec, r, ok);
        `CHK(r, LRE_RESP_OKAY)
        for (k = 0; k < 50 && execDone !== 1'b1; k++) @(posedge clock);
        if (execDone !== 1'b1) begin
            mismatches++;
            test_done();
        end
        `CHK(destResult, expDest)
        `CHK(extensionRegister, rot)
        `CHK(cr0Field, expCr0)
        @(posedge clock);
        `CHK(execDone, 1'b0)
        rd(LRE_OFF_XER, LRE_RESP_OKAY, d);
        `CHK(d, c.xer)
        rd(LRE_OFF_DEST, LRE_RESP_OKAY, d);
        `CHK(d, expDest)
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        mismatches = 0;
        nTests = 0;
        expCr0 = LRE_RESET_CR0;
        cases[0] = '{LRE_OP_REG_MERGE, 32'h9000_3000, 32'h0000_0004, 5'h00,
                     1'b0, 32'hFFFF_FFFF, 32'h0000_0000};
        cases[1] = '{LRE_OP_REG_MERGE, 32'hB004_3000, 32'hFFFF_FFE4, 5'h00,
                     1'b1, 32'hFFFF_FFFF, 32'h0000_0000};
        cases[2] = '{LRE_OP_IMM_MASK, 32'h1234_5678, 32'h0000_0007, 5'h14,
                     1'b0, 32'h0000_0000, 32'h0000_0000};
        cases[3] = '{LRE_OP_IMM_MASK, 32'h1234_5678, 32'h0000_0000, 5'h10,
                     1'b1, 32'hAAAA_5555, 32'h8000_0000};
        cases[4] = '{LRE_OP_IMM_MERGE, 32'h9000_3000, 32'h0000_0009, 5'h03,
                     1'b0, 32'hFFFF_FFFF, 32'h0000_0000};
        cases[5] = '{LRE_OP_IMM_MERGE, 32'h8000_0001, 32'h0000_0000, 5'h1F,
                     1'b1, 32'h0F0F_0F0F, 32'hE000_0000};
        cases[6] = '{LRE_OP_IMM_MASK, 32'h0000_0000, 32'h0000_0000, 5'h00,
                     1'b1, 32'h1111_1111, 32'h0000_0000};
        cases[7] = '{LRE_OP_REG_MERGE, 32'hF000_0000, 32'h0000_0000, 5'h00,
                     1'b1, 32'h1234_5678, 32'h0000_0000};
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        rd(LRE_OFF_EXT, LRE_RESP_OKAY, rdVal);
        `CHK(rdVal, LRE_RESET_WORD)
        rd(LRE_OFF_CR0, LRE_RESP_OKAY, rdVal);
        `CHK(rdVal[3:0], LRE_RESET_CR0)
        wr(LRE_OFF_DEST, 32'h0000_00FF, 4'hF, LRE_RESP_SLVERR);
        wr(LRE_OFF_SOURCE, 32'hA5A5_A5A5, 4'hF, LRE_RESP_OKAY);
        wr(LRE_OFF_SOURCE, 32'h1234_5678, 4'h6, LRE_RESP_OKAY);
        rd(LRE_OFF_SOURCE, LRE_RESP_OKAY, rdVal);
        `CHK(rdVal, 32'hA534_56A5)
        rd(8'h40, LRE_RESP_SLVERR, rdVal);
        `CHK(rdVal, LRE_RESET_WORD)
        rd(LRE_OFF_DEST, LRE_RESP_OKAY, rdVal);
        `CHK(rdVal, LRE_RESET_WORD)
        foreach (cases[i]) runCase(cases[i]);
        wr(LRE_OFF_CMD, 32'h0000_0303, 4'hF, LRE_RESP_OKAY);
        repeat (4) @(posedge clock);
        `CHK(cr0Field, expCr0)
        rd(LRE_OFF_STATUS, LRE_RESP_OKAY, rdVal);
        `CHK(rdVal, 32'h0000_000B)
        test_done();
    end
endmodule // lre_rotate_unit_tb
